// ---- core/cbx_alu.sv ----
`timescale 1ns/1ps
module cbx_alu
    import cbx_pkg::*;
(
    input wire cbx_op_t op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] lit_i,
    input wire logic dest_i,
    cbx_res_if.alu_mp res
);
    logic [7:0] r;

    always_comb begin
        r = file_i;
        res.carry_out = 1'b0;
        res.carry_we = 1'b0;
        res.zero_we = 1'b0;
        res.dest_file = (dest_i == CBX_DEST_FILE);
        res.skip = 1'b0;
        case (op_i)
            CBX_OP_INCREMENT_FILE: begin
                r = file_i + 8'h01;
                res.zero_we = 1'b1;
            end
            CBX_OP_INCREMENT_SKIP_ON_NULL: begin
                r = file_i + 8'h01;
                // flags untouched, zero result only skips
                res.skip = (r == 8'h00);
            end
            CBX_OP_OR_LITERAL_ACCUMULATOR: begin
                r = acc_i | lit_i;
                res.zero_we = 1'b1;
                res.dest_file = 1'b0;
            end
            CBX_OP_OR_ACCUMULATOR_FILE: begin
                r = acc_i | file_i;
                res.zero_we = 1'b1;
            end
            CBX_OP_SHIFT_LEFT_FILE: begin
                r = {file_i[6:0], 1'b0};
                res.carry_out = file_i[7];
                res.carry_we = 1'b1;
                res.zero_we = 1'b1;
            end
            CBX_OP_SHIFT_RIGHT_FILE: begin
                r = {1'b0, file_i[7:1]};
                res.carry_out = file_i[0];
                res.carry_we = 1'b1;
                res.zero_we = 1'b1;
            end
            default: begin
                res.dest_file = 1'b0;
            end
        endcase
        res.result = r;
        res.zero_out = (r == 8'h00);
    end
endmodule

// ---- core/cbx_exec.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Operation
// - jump loads its 11-bit literal into counter bits 10:0.
// - jump fills counter bits 14:11 from jump high latch bits 6:3.
// - jump takes two cycles and changes no status flag.
// - destination bit 0 writes accumulator, 1 writes the file register.
// - increment file adds one, writes destination, updates zero.
// - increment skip adds one; zero result replaces next op, no flags.
// - or literal ORs accumulator with 8-bit literal, zero updated.
// - or file ORs accumulator with file, writes destination, zero.
// - shift left sends file bit 7 to carry, 6:0 to dest 7:1.
// - shift left clears dest bit 0, updates carry and zero.
// - shift right clears dest bit 7, bit 0 to carry, flags updated.
module cbx_exec
    import cbx_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // decoded instruction
    input wire logic OP_VALID_I,
    input wire cbx_op_t OP_I,
    input wire logic [10:0] JUMP_LIT_I,
    input wire logic [7:0] LIT_I,
    input wire logic [6:0] FILE_ADDR_I,
    input wire logic DEST_I,
    // register file and latch
    input wire logic [7:0] FILE_RDATA_I,
    input wire logic [7:0] JUMP_HIGH_LATCH_I,
    output logic [6:0] FILE_ADDR_O,
    output logic [7:0] FILE_WDATA_O,
    output logic FILE_WE_O,
    // program counter
    output logic PC_LOAD_O,
    output logic [14:0] PC_VALUE_O,
    // accumulator and flags
    output logic [7:0] ACC_O,
    output logic CARRY_O,
    output logic ZERO_O,
    // pipeline control
    output logic READY_O,
    output logic FLUSH_O
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [7:0] acc;
        logic carry;
        logic zero;
        logic [6:0] faddr;
        logic [7:0] fwdata;
        logic fwe;
        logic pc_load;
        logic [14:0] pc_val;
        logic busy;
        logic flush;
    } cbx_state_t;

    cbx_state_t s_q;
    cbx_state_t s_d;
    logic rst_n;
    logic [14:0] jump_target;

    cbx_res_if res ();

    cbx_alu u_alu (
        .op_i(OP_VALID_I && !s_q.busy ? OP_I : CBX_OP_NONE),
        .acc_i(s_q.acc),
        .file_i(FILE_RDATA_I),
        .lit_i(LIT_I),
        .dest_i(DEST_I),
        .res(res)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops, kept apart from the state struct
    logic [1:0] rsync_q;
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_n = rsync_q[1];

    assign jump_target = {
        JUMP_HIGH_LATCH_I[CBX_LATCH_HI_MSB:CBX_LATCH_HI_LSB],
        JUMP_LIT_I
    };

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.rst_sync = 2'h0;
        s_d.fwe = 1'b0;
        s_d.pc_load = 1'b0;
        s_d.flush = 1'b0;
        // second cycle of a two-cycle op: the slot is a no-operation
        s_d.busy = 1'b0;
        if (OP_VALID_I && !s_q.busy) begin
            if (OP_I == CBX_OP_ABSOLUTE_JUMP) begin
                s_d.pc_load = 1'b1;
                s_d.pc_val = jump_target;
                s_d.busy = 1'b1;
                s_d.flush = 1'b1;
            end else if (OP_I != CBX_OP_NONE) begin
                if (res.dest_file) begin
                    s_d.fwe = 1'b1;
                    s_d.faddr = FILE_ADDR_I;
                    s_d.fwdata = res.result;
                end else begin
                    s_d.acc = res.result;
                end
                if (res.zero_we) begin
                    s_d.zero = res.zero_out;
                end
                if (res.carry_we) begin
                    s_d.carry = res.carry_out;
                end
                if (res.skip) begin
                    // next fetched op is discarded, costing a cycle
                    s_d.busy = 1'b1;
                    s_d.flush = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.acc <= CBX_ACC_RST;
            s_q.pc_val <= CBX_PC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign FILE_ADDR_O = s_q.faddr;
    assign FILE_WDATA_O = s_q.fwdata;
    assign FILE_WE_O = s_q.fwe;
    assign PC_LOAD_O = s_q.pc_load;
    assign PC_VALUE_O = s_q.pc_val;
    assign ACC_O = s_q.acc;
    assign CARRY_O = s_q.carry;
    assign ZERO_O = s_q.zero;
    // jump and skip leave flags alone: no flag write path for them
    assign READY_O = !s_q.busy;
    assign FLUSH_O = s_q.flush;

endmodule

// ---- core/cbx_pkg.sv ----
package cbx_pkg;

    // operation select codes presented by the decoder
    typedef enum logic [2:0] {
        CBX_OP_NONE,
        CBX_OP_ABSOLUTE_JUMP,
        CBX_OP_INCREMENT_FILE,
        CBX_OP_INCREMENT_SKIP_ON_NULL,
        CBX_OP_OR_LITERAL_ACCUMULATOR,
        CBX_OP_OR_ACCUMULATOR_FILE,
        CBX_OP_SHIFT_LEFT_FILE,
        CBX_OP_SHIFT_RIGHT_FILE
    } cbx_op_t;

    // widths
    localparam int CBX_DATA_W = 8;
    localparam int CBX_PC_W = 15;
    localparam int CBX_JUMP_LIT_W = 11;
    localparam int CBX_FILE_ADDR_W = 7;

    // jump high latch field feeding the upper program counter bits
    localparam int CBX_LATCH_HI_MSB = 6;
    localparam int CBX_LATCH_HI_LSB = 3;

    // destination select encodings
    localparam logic CBX_DEST_ACC = 1'b0;
    localparam logic CBX_DEST_FILE = 1'b1;

    // reset values
    localparam logic [7:0] CBX_ACC_RST = 8'h00;
    localparam logic [14:0] CBX_PC_RST = 15'h0000;

    // cycle counts
    localparam logic [1:0] CBX_CYC_ONE = 2'h1;
    localparam logic [1:0] CBX_CYC_TWO = 2'h2;

endpackage

// ---- core/cbx_res_if.sv ----
`timescale 1ns/1ps
interface cbx_res_if;
    import cbx_pkg::*;
    logic [7:0] result;
    logic carry_out;
    logic zero_out;
    logic carry_we;
    logic zero_we;
    logic dest_file;
    logic skip;
    modport alu_mp (
        output result, carry_out, zero_out, carry_we, zero_we,
        output dest_file, skip
    );
    modport core_mp (
        input result, carry_out, zero_out, carry_we, zero_we,
        input dest_file, skip
    );
endinterface

// ---- tb/cbx_exec_asserts.sv ----
`timescale 1ns/1ps
module cbx_exec_chk
    import cbx_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic OP_VALID_I,
    input wire cbx_op_t OP_I,
    input wire logic [10:0] JUMP_LIT_I,
    input wire logic [7:0] LIT_I,
    input wire logic DEST_I,
    input wire logic [7:0] FILE_RDATA_I,
    input wire logic [7:0] JUMP_HIGH_LATCH_I,
    input wire logic [7:0] FILE_WDATA_O,
    input wire logic FILE_WE_O,
    input wire logic PC_LOAD_O,
    input wire logic [14:0] PC_VALUE_O,
    input wire logic [7:0] ACC_O,
    input wire logic CARRY_O,
    input wire logic ZERO_O,
    input wire logic READY_O,
    input wire logic FLUSH_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    wire go = OP_VALID_I && READY_O;
    wire [7:0] f = FILE_RDATA_I;
    wire [3:0] hi = JUMP_HIGH_LATCH_I[6:3];
    // result as seen at whichever destination was written
    wire [7:0] rs = FILE_WE_O ? FILE_WDATA_O : ACC_O;
    sequence gap_s;
        !READY_O && FLUSH_O ##1 READY_O;
    endsequence
    jump_pc_a: assert property (
        go && OP_I == CBX_OP_ABSOLUTE_JUMP |=>
        PC_LOAD_O && PC_VALUE_O == {$past(hi), $past(JUMP_LIT_I)})
        else $error("jump target wrong");
    jump_gap_a: assert property (
        go && OP_I == CBX_OP_ABSOLUTE_JUMP |=>
        gap_s and ($stable(CARRY_O) && $stable(ZERO_O)))
        else $error("jump slot wrong");
    dest_sel_a: assert property (
        go && OP_I inside {CBX_OP_INCREMENT_FILE, CBX_OP_SHIFT_LEFT_FILE,
        CBX_OP_OR_ACCUMULATOR_FILE, CBX_OP_SHIFT_RIGHT_FILE} |=>
        FILE_WE_O == $past(DEST_I)) else $error("dest wrong");
    increment_file_res_a: assert property (
        go && OP_I == CBX_OP_INCREMENT_FILE |=>
        rs == $past(f) + 8'h01 && ZERO_O == (rs == 8'h00))
        else $error("increment wrong");
    skip_null_a: assert property (
        go && OP_I == CBX_OP_INCREMENT_SKIP_ON_NULL |=>
        FLUSH_O == ($past(f) == 8'hff) && $stable(ZERO_O))
        else $error("skip wrong");
    or_lit_a: assert property (
        go && OP_I == CBX_OP_OR_LITERAL_ACCUMULATOR |=>
        ACC_O == ($past(ACC_O) | $past(LIT_I)) && ZERO_O == (ACC_O == 0))
        else $error("or literal wrong");
    or_file_a: assert property (
        go && OP_I == CBX_OP_OR_ACCUMULATOR_FILE |=>
        rs == ($past(ACC_O) | $past(f)) && ZERO_O == (rs == 8'h00))
        else $error("or file wrong");
    shl_res_a: assert property (
        go && OP_I == CBX_OP_SHIFT_LEFT_FILE |=>
        rs == {$past(f[6:0]), 1'b0} && CARRY_O == $past(f[7]))
        else $error("shift left wrong");
    shr_res_a: assert property (
        go && OP_I == CBX_OP_SHIFT_RIGHT_FILE |=>
        rs == {1'b0, $past(f[7:1])} && CARRY_O == $past(f[0]))
        else $error("shift right wrong");
endmodule
bind cbx_exec cbx_exec_chk cbx_exec_chk_inst (.*);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench import cbx_pkg::*;;
    logic clk = 0, rst_n = 0, vld = 0, dst = 0, c = 0, z = 0;
    cbx_op_t op = CBX_OP_NONE;
    logic [10:0] jl = 0;
    logic [7:0] lit = 0, rd = 0, hl = 0, acc = 0, wd, acco;
    logic [6:0] fa = 0, fao;
    logic [15:0] r = 16'h3;
    logic [14:0] pcv;
    logic we, pcl, co, zo, rdy, fl;
    int fail_count = 0, checks = 0;
    cbx_exec cbx_exec_inst (.CORE_CLK_I(clk), .ARST_N_I(rst_n),
        .OP_VALID_I(vld), .OP_I(op), .JUMP_LIT_I(jl), .LIT_I(lit),
        .FILE_ADDR_I(fa), .DEST_I(dst), .FILE_RDATA_I(rd),
        .JUMP_HIGH_LATCH_I(hl), .FILE_ADDR_O(fao), .FILE_WDATA_O(wd),
        .FILE_WE_O(we), .PC_LOAD_O(pcl), .PC_VALUE_O(pcv), .ACC_O(acco),
        .CARRY_O(co), .ZERO_O(zo), .READY_O(rdy), .FLUSH_O(fl));
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, s, e);
        end
    endtask
    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // returns carry and result; carry passes through where untouched
    function logic [8:0] calc(cbx_op_t o, logic [7:0] a, f, k, logic ci);
        case (o)
            CBX_OP_INCREMENT_FILE, CBX_OP_INCREMENT_SKIP_ON_NULL:
                return {ci, f + 8'h01};
            CBX_OP_OR_LITERAL_ACCUMULATOR: return {ci, a | k};
            CBX_OP_OR_ACCUMULATOR_FILE: return {ci, a | f};
            CBX_OP_SHIFT_LEFT_FILE: return {f, 1'b0};
            default: return {f[0], 1'b0, f[7:1]};
        endcase
    endfunction
    task end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task run(cbx_op_t o, logic [7:0] f, logic [7:0] k, logic d);
        logic [8:0] x;
        logic hold;
        logic wee;
        x = calc(o, acc, f, k, c);
        hold = o == CBX_OP_ABSOLUTE_JUMP ||
            (o == CBX_OP_INCREMENT_SKIP_ON_NULL && x[7:0] == 8'h00);
        wee = d && o != CBX_OP_OR_LITERAL_ACCUMULATOR && !hold;
        wee = wee || (d && o == CBX_OP_INCREMENT_SKIP_ON_NULL);
        @(posedge clk);
        vld <= 1;
        op <= o;
        rd <= f;
        lit <= k;
        dst <= d;
        jl <= r[10:0];
        hl <= r[15:8];
        fa <= r[6:0];
        @(posedge clk);
        // after a jump or zero skip, offer an or-literal of all ones that must be refused
        vld <= hold;
        op <= CBX_OP_OR_LITERAL_ACCUMULATOR;
        lit <= 8'hff;
        rd <= ~f;
        #1;
        if (o == CBX_OP_ABSOLUTE_JUMP) begin
            chk(pcv, {hl[6:3], jl});
            chk(pcl, 1);
        end else begin
            chk(we, wee);
            if (wee)
                chk({fao, wd}, {fa, x[7:0]});
            else
                acc = x[7:0];
            if (o != CBX_OP_INCREMENT_SKIP_ON_NULL)
                z = x[7:0] == 8'h00;
            c = x[8];
        end
        chk({acco, zo, co}, {acc, z, c});
        chk({fl, rdy}, {hold, !hold});
        if (hold) begin
            @(posedge clk);
            vld <= 0;
            #1;
            chk({acco, rdy}, {acc, 1'b1});
        end
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        run(CBX_OP_INCREMENT_FILE, 8'hff, 8'h00, 1);
        run(CBX_OP_INCREMENT_SKIP_ON_NULL, 8'hff, 8'h00, 0);
        run(CBX_OP_OR_LITERAL_ACCUMULATOR, 8'h00, 8'h00, 1);
        run(CBX_OP_SHIFT_LEFT_FILE, 8'h80, 8'h00, 0);
        run(CBX_OP_SHIFT_RIGHT_FILE, 8'h01, 8'h00, 1);
        r = 16'hffff;
        run(CBX_OP_ABSOLUTE_JUMP, 8'h00, 8'h00, 0);
        r = 16'h3;
        repeat (300) begin
            r = lfsr(r);
            run(cbx_op_t'(3'(r[2:0] % 7 + 1)), r[15:8], r[7:0], r[3]);
        end
        end_sim;
    end
endmodule
